/* File: amp_event_flags.sv */
// Purpose: Sticky event state and maskable flags with interrupt pulse
// Assumes: Raw indicators and clear pulses synchronous to clk_i
// Notes:   Register reads return data one cycle after the strobe
//
// Notes on behaviour
// - Brownout level-zero entry state, bit 3, latches raw rise until cleared.
// - Brownout level-change state, bit 2, latches raw rise until cleared.
// - Brownout active-begin state, bit 1, latches raw rise until cleared.
// - Brownout active-end state, bit 0, latches raw rise until cleared.
// - Brownout state bits 7..4 unused; state bits read-only, reset zero.
// - A flag rises only with unmask high and an edge since clear.
// - Each flag rising edge raises an interrupt while interrupts are enabled.
// - Thermal shutdown begin bit 7, end bit 6, own unmask and clear.
// - Thermal warning one begin bit 5, end bit 4.
// - Thermal foldback begin bit 3, end bit 2.
// - Fuse-load failure bit 1, speaker overcurrent bit 0.
// - Thermal warning two begin bit 7, end bit 6.
// - Speaker data monitor error bit 5, clock monitor error bit 4.
// - PCM clock recovery flag bit 2; bit 3 unused.
// - PCM clock error bit 1, PCM data error bit 0.
// - All flag bits read-only and reset to zero.
// - Unmask zero keeps flag low; unmask one follows edges since clear.
// - Fuse-load unmask resets to one, other first-group unmasks to zero.
`timescale 1ns/1ps
`default_nettype none
module amp_event_flags
  import amp_event_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  input  wire logic [3:0]        brownout_raw_i,
  input  wire logic [3:0]        brownout_clear_i,
  input  wire logic [7:0]        fault_raw_i,
  input  wire logic [7:0]        fault_clear_i,
  input  wire logic [7:0]        monitor_raw_i,
  input  wire logic [7:0]        monitor_clear_i,
  input  wire logic              irq_enable_i,
  input  wire logic              reg_rd_i,
  input  wire logic              reg_wr_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [REG_W-1:0]  reg_wdata_i,
  output logic      [REG_W-1:0]  reg_rdata_o,
  output logic                   reg_rvalid_o,
  output logic                   irq_o
);

  // Number of events in the bank: two flag groups plus brownout
  localparam int NUM_EV   = 20;
  localparam int FAULT_LO = 0;
  localparam int MON_LO   = 8;
  localparam int BO_LO    = 16;

  // Reset release through two flops
  logic rst_sync1_r;
  logic rst_sync2_r;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync1_r <= 1'b0;
      rst_sync2_r <= 1'b0;
    end else begin
      rst_sync1_r <= 1'b1;
      rst_sync2_r <= rst_sync1_r;
    end
  end

  logic rst_n;
  assign rst_n = rst_sync2_r;

  // Carrier to the sticky bank
  event_bank_if #(.N(NUM_EV)) ev ();

  // Unmask register outputs
  logic [REG_W-1:0] fault_unmask;
  logic [REG_W-1:0] monitor_unmask;

  // Writable unmask registers
  unmask_regs u_unmask (
    .addr_i           (reg_addr_i),
    .clk_i            (clk_i),
    .rst_n_i          (rst_n),
    .wr_i             (reg_wr_i),
    .wdata_i          (reg_wdata_i),
    .fault_unmask_o   (fault_unmask),
    .monitor_unmask_o (monitor_unmask)
  );

  // Sticky edge capture for every event
  sticky_event_bank #(.N(NUM_EV)) u_bank (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .ev      (ev)
  );

  // Masked raw for the monitor group; unused bit never fires
  logic [7:0] monitor_raw_used;
  logic [7:0] monitor_clear_used;
  assign monitor_raw_used   = monitor_raw_i & MONITOR_USED_MASK;
  assign monitor_clear_used = monitor_clear_i & MONITOR_USED_MASK;

  // Raw indicators into the bank
  // Sampled edges in clk_i
  assign ev.raw = {brownout_raw_i, monitor_raw_used, fault_raw_i};

  // One clear hits state and flag
  assign ev.clr = {brownout_clear_i, monitor_clear_used, fault_clear_i};

  // Brownout events are unmaskable; only their state is read
  // Unmask gates each flag
  assign ev.unmask = {4'hF, monitor_unmask & MONITOR_USED_MASK, fault_unmask};

  // Brownout state register fields
  logic brownout_level_zero_entry_state;
  logic brownout_level_change_state;
  logic brownout_active_begin_state;
  logic brownout_active_end_state;

  assign brownout_level_zero_entry_state = ev.state[BO_LO + BO_LEVEL_ZERO_BIT];
  assign brownout_level_change_state     = ev.state[BO_LO + BO_LEVEL_CHANGE_BIT];
  assign brownout_active_begin_state     = ev.state[BO_LO + BO_ACTIVE_BEGIN_BIT];
  assign brownout_active_end_state       = ev.state[BO_LO + BO_ACTIVE_END_BIT];

  // First flag group fields
  logic thermal_shutdown_begin_flag;
  logic thermal_shutdown_end_flag;
  logic thermal_warning_one_begin_flag;
  logic thermal_warning_one_end_flag;
  logic thermal_foldback_begin_flag;
  logic thermal_foldback_end_flag;
  logic fuse_load_failure_flag;
  logic speaker_overcurrent_flag;

  assign thermal_shutdown_begin_flag    = ev.flag[FAULT_LO + TSD_BEGIN_BIT];
  assign thermal_shutdown_end_flag      = ev.flag[FAULT_LO + TSD_END_BIT];
  assign thermal_warning_one_begin_flag = ev.flag[FAULT_LO + TW1_BEGIN_BIT];
  assign thermal_warning_one_end_flag   = ev.flag[FAULT_LO + TW1_END_BIT];
  assign thermal_foldback_begin_flag    = ev.flag[FAULT_LO + TFB_BEGIN_BIT];
  assign thermal_foldback_end_flag      = ev.flag[FAULT_LO + TFB_END_BIT];
  assign fuse_load_failure_flag         = ev.flag[FAULT_LO + FUSE_LOAD_FAIL_BIT];
  assign speaker_overcurrent_flag       = ev.flag[FAULT_LO + SPK_OVERCURRENT_BIT];

  // Second flag group fields
  logic thermal_warning_two_begin_flag;
  logic thermal_warning_two_end_flag;
  logic internal_speaker_monitor_error_flag;
  logic internal_clock_monitor_error_flag;
  logic pcm_clock_recovery_flag;
  logic pcm_clock_error_flag;
  logic pcm_data_input_error_flag;

  assign thermal_warning_two_begin_flag      = ev.flag[MON_LO + TW2_BEGIN_BIT];
  assign thermal_warning_two_end_flag        = ev.flag[MON_LO + TW2_END_BIT];
  assign internal_speaker_monitor_error_flag = ev.flag[MON_LO + SPK_MONITOR_ERR_BIT];
  assign internal_clock_monitor_error_flag   = ev.flag[MON_LO + CLK_MONITOR_ERR_BIT];
  assign pcm_clock_recovery_flag             = ev.flag[MON_LO + PCM_CLK_RECOVER_BIT];
  assign pcm_clock_error_flag                = ev.flag[MON_LO + PCM_CLK_ERR_BIT];
  assign pcm_data_input_error_flag           = ev.flag[MON_LO + PCM_DATA_ERR_BIT];

  // Register images
  logic [REG_W-1:0] brownout_image;
  logic [REG_W-1:0] fault_image;
  logic [REG_W-1:0] monitor_image;

  assign brownout_image = {4'h0,
                           brownout_level_zero_entry_state,
                           brownout_level_change_state,
                           brownout_active_begin_state,
                           brownout_active_end_state};

  assign fault_image = {thermal_shutdown_begin_flag,
                        thermal_shutdown_end_flag,
                        thermal_warning_one_begin_flag,
                        thermal_warning_one_end_flag,
                        thermal_foldback_begin_flag,
                        thermal_foldback_end_flag,
                        fuse_load_failure_flag,
                        speaker_overcurrent_flag};

  // Unused bit 3 is a hard zero
  assign monitor_image = {thermal_warning_two_begin_flag,
                          thermal_warning_two_end_flag,
                          internal_speaker_monitor_error_flag,
                          internal_clock_monitor_error_flag,
                          1'b0,
                          pcm_clock_recovery_flag,
                          pcm_clock_error_flag,
                          pcm_data_input_error_flag};

  // Read decode; writes to status offsets are ignored
  logic hit_brownout;
  logic hit_fault_flags;
  logic hit_monitor_flags;
  logic hit_fault_unmask;
  logic hit_monitor_unmask;
  assign hit_brownout       = (reg_addr_i == BROWNOUT_EVENT_STATE);
  assign hit_fault_flags    = (reg_addr_i == THERMAL_FAULT_FLAGS);
  assign hit_monitor_flags  = (reg_addr_i == MONITOR_CLOCK_FLAGS);
  assign hit_fault_unmask   = (reg_addr_i == FAULT_UNMASK_REG);
  assign hit_monitor_unmask = (reg_addr_i == MONITOR_UNMASK_REG);

  // Read data selection; unmapped offsets read zero
  // Flag registers are read-only
  // Live unmask gate; the flag flop lags an unmask clear by a cycle
  logic [REG_W-1:0] rdata_nxt;
  assign rdata_nxt = hit_brownout       ? brownout_image                   :
                     hit_fault_flags    ? (fault_image & fault_unmask)     :
                     hit_monitor_flags  ? (monitor_image & monitor_unmask) :
                     hit_fault_unmask   ? fault_unmask   :
                     hit_monitor_unmask ? monitor_unmask :
                                          UNMAPPED_READ;

  // Read data held until the next read strobe
  logic [REG_W-1:0] rdata_r;
  logic             rvalid_r;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r  <= UNMAPPED_READ;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= reg_rd_i;
      if (reg_rd_i) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  // Any flag going high this cycle; brownout events excluded
  logic any_flag_rise;
  // Flag edge gated by irq enable
  assign any_flag_rise = |ev.flag_rise[MON_LO+7:FAULT_LO] & irq_enable_i;

  // Interrupt is a one-cycle pulse aligned with the flag going high
  logic irq_r;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= any_flag_rise;
    end
  end

  // Outputs straight from flops
  assign reg_rdata_o  = rdata_r;
  assign reg_rvalid_o = rvalid_r;
  assign irq_o        = irq_r;

endmodule : amp_event_flags
`default_nettype wire

/* File: amp_event_pkg.sv */
// Purpose: Shared constants for the amplifier event flag logic
// Assumes: Eight-bit registers on a sixteen-bit control address
// Notes:   Event vector index = bit position in its register group
`default_nettype none
package amp_event_pkg;
  localparam int          REG_W                 = 8;
  localparam int          ADDR_W                = 16;
  // Register offsets
  localparam logic [15:0] BROWNOUT_EVENT_STATE  = 16'h2009;
  localparam logic [15:0] THERMAL_FAULT_FLAGS   = 16'h200B;
  localparam logic [15:0] MONITOR_CLOCK_FLAGS   = 16'h200C;
  localparam logic [15:0] FAULT_UNMASK_REG      = 16'h2010;
  localparam logic [15:0] MONITOR_UNMASK_REG    = 16'h2011;
  // Reset values
  localparam logic [7:0]  STATE_RESET           = 8'h00;
  localparam logic [7:0]  FLAG_RESET            = 8'h00;
  localparam logic [7:0]  FAULT_UNMASK_RESET    = 8'h02;
  localparam logic [7:0]  MONITOR_UNMASK_RESET  = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ         = 8'h00;
  // Brownout state register fields
  localparam int          BO_LEVEL_ZERO_BIT     = 3;
  localparam int          BO_LEVEL_CHANGE_BIT   = 2;
  localparam int          BO_ACTIVE_BEGIN_BIT   = 1;
  localparam int          BO_ACTIVE_END_BIT     = 0;
  localparam logic [7:0]  BO_USED_MASK          = 8'h0F;
  // Thermal and fault flag fields
  localparam int          TSD_BEGIN_BIT         = 7;
  localparam int          TSD_END_BIT           = 6;
  localparam int          TW1_BEGIN_BIT         = 5;
  localparam int          TW1_END_BIT           = 4;
  localparam int          TFB_BEGIN_BIT         = 3;
  localparam int          TFB_END_BIT           = 2;
  localparam int          FUSE_LOAD_FAIL_BIT    = 1;
  localparam int          SPK_OVERCURRENT_BIT   = 0;
  // Monitor and clock flag fields
  localparam int          TW2_BEGIN_BIT         = 7;
  localparam int          TW2_END_BIT           = 6;
  localparam int          SPK_MONITOR_ERR_BIT   = 5;
  localparam int          CLK_MONITOR_ERR_BIT   = 4;
  localparam int          MONITOR_UNUSED_BIT    = 3;
  localparam int          PCM_CLK_RECOVER_BIT   = 2;
  localparam int          PCM_CLK_ERR_BIT       = 1;
  localparam int          PCM_DATA_ERR_BIT      = 0;
  localparam logic [7:0]  MONITOR_USED_MASK     = 8'hF7;
endpackage : amp_event_pkg
`default_nettype wire

/* File: event_bank_if.sv */
// Purpose: Carrier between the top and the sticky event bank
// Assumes: One clock domain, all signals synchronous
// Notes:   Clear is a one-cycle pulse per event
`timescale 1ns/1ps
`default_nettype none
interface event_bank_if #(
  parameter int N = 8
);
  logic [N-1:0] raw;
  logic [N-1:0] clr;
  logic [N-1:0] unmask;
  logic [N-1:0] state;
  logic [N-1:0] flag;
  logic [N-1:0] flag_rise;
  modport bank (input raw, input clr, input unmask,
                output state, output flag, output flag_rise);
  modport user (output raw, output clr, output unmask,
                input state, input flag, input flag_rise);
endinterface : event_bank_if
`default_nettype wire

/* File: sticky_event_bank.sv */
// Purpose: Per-event edge capture with sticky state and unmasked flag
// Assumes: Raw indicators synchronous to clk_i
// Notes:   Set beats clear when both fall in the same cycle
`timescale 1ns/1ps
`default_nettype none
module sticky_event_bank
  import amp_event_pkg::*;
#(
  parameter int N = 8
) (
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  event_bank_if.bank  ev
);
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_event
      logic raw_q_r;
      logic state_r;
      logic flag_r;
      logic rise;
      logic state_nxt;
      logic flag_nxt;
      // Rising edge seen against last sampled raw
      assign rise      = ev.raw[i] & ~raw_q_r;
      // New edge wins over a coincident clear
      assign state_nxt = rise | (state_r & ~ev.clr[i]);
      // Flag is the state gated by its unmask
      assign flag_nxt  = state_nxt & ev.unmask[i];
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          raw_q_r <= 1'b0;
          state_r <= 1'b0;
          flag_r  <= 1'b0;
        end else begin
          raw_q_r <= ev.raw[i];
          state_r <= state_nxt;
          flag_r  <= flag_nxt;
        end
      end
      assign ev.state[i]     = state_r;
      assign ev.flag[i]      = flag_r;
      // Pulse in the cycle the flag register will go high
      assign ev.flag_rise[i] = flag_nxt & ~flag_r;
    end
  endgenerate
endmodule : sticky_event_bank
`default_nettype wire

/* File: unmask_regs.sv */
// Purpose: Writable unmask registers for the maskable flags
// Assumes: Single-cycle write strobe with address and data
// Notes:   Unused monitor bit is not stored and reads zero
`timescale 1ns/1ps
`default_nettype none
module unmask_regs
  import amp_event_pkg::*;
(
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              wr_i,
  input  wire logic [REG_W-1:0]  wdata_i,
  output logic      [REG_W-1:0]  fault_unmask_o,
  output logic      [REG_W-1:0]  monitor_unmask_o
);
  logic [REG_W-1:0] fault_r;
  logic [REG_W-1:0] monitor_r;
  logic             hit_fault;
  logic             hit_monitor;
  // Address decode for the two writable registers
  assign hit_fault   = wr_i && (addr_i == FAULT_UNMASK_REG);
  assign hit_monitor = wr_i && (addr_i == MONITOR_UNMASK_REG);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_r   <= FAULT_UNMASK_RESET;
      monitor_r <= MONITOR_UNMASK_RESET;
    end else begin
      if (hit_fault) begin
        fault_r <= wdata_i;
      end
      if (hit_monitor) begin
        monitor_r <= wdata_i & MONITOR_USED_MASK;
      end
    end
  end
  assign fault_unmask_o   = fault_r;
  assign monitor_unmask_o = monitor_r;
endmodule : unmask_regs
`default_nettype wire

/* File: amp_event_flags_monitor.sv */
// Purpose: Port-level checks for the amplifier event flag block
// Assumes: One clock, active-low reset on resetn_i
// Notes:   Only top ports are visible; flag contents are judged by the bench
`timescale 1ns/1ps
`default_nettype none
module amp_event_flags_monitor
  import amp_event_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              resetn_i,
  input wire logic [3:0]        brownout_raw_i,
  input wire logic [3:0]        brownout_clear_i,
  input wire logic [7:0]        fault_raw_i,
  input wire logic [7:0]        fault_clear_i,
  input wire logic [7:0]        monitor_raw_i,
  input wire logic [7:0]        monitor_clear_i,
  input wire logic              irq_enable_i,
  input wire logic              reg_rd_i,
  input wire logic              reg_wr_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [REG_W-1:0]  reg_wdata_i,
  input wire logic [REG_W-1:0]  reg_rdata_o,
  input wire logic              reg_rvalid_o,
  input wire logic              irq_o
);
  // Address decode, so unmapped reads can be judged
  wire logic addr_mapped = (reg_addr_i == BROWNOUT_EVENT_STATE) ||
                           (reg_addr_i == THERMAL_FAULT_FLAGS) ||
                           (reg_addr_i == MONITOR_CLOCK_FLAGS) ||
                           (reg_addr_i == FAULT_UNMASK_REG) ||
                           (reg_addr_i == MONITOR_UNMASK_REG);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  // Read path timing and holding
  AST_RD_ANSWER:
    assert property (reg_rd_i |=> reg_rvalid_o) else $error("Read strobe got no answer");
  AST_RVALID_CAUSE:
    assert property (reg_rvalid_o |-> $past(reg_rd_i)) else $error("Answer without a read");
  AST_RDATA_HOLD:
    assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o)) else $error("Read data moved");
  // Unused bits and unmapped places read zero
  AST_BO_UNUSED:
    assert property (reg_rd_i && reg_addr_i == BROWNOUT_EVENT_STATE |=> reg_rdata_o[7:4] == 4'h0)
      else $error("Brownout upper bits not zero");
  AST_MON_UNUSED:
    assert property (reg_rd_i && reg_addr_i == MONITOR_CLOCK_FLAGS |=> !reg_rdata_o[3])
      else $error("Monitor bit 3 not zero");
  AST_UNMAPPED:
    assert property (reg_rd_i && !addr_mapped |=> reg_rdata_o == 8'h00)
      else $error("Unmapped read not zero");
  // Interrupt only while its output is enabled
  AST_IRQ_GATED:
    assert property (irq_o |-> $past(irq_enable_i))
      else $error("Interrupt while disabled");
  // Outputs quiet in reset; interrupt quiet for two cycles after release
  AST_RESET_QUIET:
    assert property (disable iff (1'b0) !resetn_i |-> !irq_o && !reg_rvalid_o &&
                     reg_rdata_o == 8'h00) else $error("Outputs active in reset");
  AST_RELEASE_QUIET:
    assert property ($rose(resetn_i) |-> !irq_o [*2]) else $error("Interrupt at reset release");

  COV_IRQ: cover property (irq_o);
  COV_BO_READ: cover property (reg_rd_i && reg_addr_i == BROWNOUT_EVENT_STATE);
  COV_UNMAPPED: cover property (reg_rd_i && !addr_mapped);
endmodule : amp_event_flags_monitor

bind amp_event_flags amp_event_flags_monitor amp_event_flags_monitor_i (
  .clk_i, .resetn_i, .brownout_raw_i, .brownout_clear_i, .fault_raw_i, .fault_clear_i,
  .monitor_raw_i, .monitor_clear_i, .irq_enable_i, .reg_rd_i, .reg_wr_i, .reg_addr_i,
  .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .irq_o
);
`default_nettype wire

/* File: test_amp_event_flags.sv */
// Purpose: Self-checking bench for the amplifier event flag block
// Assumes: Bench drives every input at the rising edge
// Notes:   Groups 0/1/2 are brownout, thermal-fault and monitor events
`timescale 1ns/1ps
`default_nettype none
module test_amp_event_flags
  import amp_event_pkg::*;
;
  logic              clk_i;
  logic              resetn_i;
  logic [3:0]        brownout_raw_i, brownout_clear_i;
  logic [7:0]        fault_raw_i, fault_clear_i, monitor_raw_i, monitor_clear_i;
  logic              irq_enable_i, reg_rd_i, reg_wr_i;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [REG_W-1:0]  reg_wdata_i, reg_rdata_o, rd_val;
  logic              reg_rvalid_o, irq_o;
  int                bad_count = 0;
  int                comparisons = 0;

  amp_event_flags amp_event_flags_i (.clk_i, .resetn_i, .brownout_raw_i, .brownout_clear_i,
    .fault_raw_i, .fault_clear_i, .monitor_raw_i, .monitor_clear_i, .irq_enable_i,
    .reg_rd_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .irq_o);

  // Free-running 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk8(string what, logic [7:0] exp, logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8

  task automatic chk1(string what, logic exp, logic got);
    chk8(what, {7'h00, exp}, {7'h00, got});
  endtask : chk1

  task automatic rd(logic [15:0] a, output logic [7:0] d);
    @(posedge clk_i) reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i) reg_rd_i <= 1'b0;
    #1 chk1("rvalid", 1'b1, reg_rvalid_o);
    d = reg_rdata_o;
  endtask : rd

  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(posedge clk_i) reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i) reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rd_chk(logic [15:0] a, logic [7:0] exp);
    rd(a, rd_val);
    chk8("register", exp, rd_val);
  endtask : rd_chk

  // Per-group drive of one raw bit and one clear bit, always from an edge
  task automatic drv(int g, int b, logic raw, logic clr);
    case (g)
      0: begin brownout_raw_i[b] <= raw; brownout_clear_i[b] <= clr; end
      1: begin fault_raw_i[b] <= raw; fault_clear_i[b] <= clr; end
      default: begin monitor_raw_i[b] <= raw; monitor_clear_i[b] <= clr; end
    endcase
  endtask : drv

  function automatic logic [15:0] addr_of(int g);
    return (g == 0) ? 16'h2009 : (g == 1) ? 16'h200B : 16'h200C;
  endfunction : addr_of

  // One raw rise: irq pulse, register content, then clear back to zero
  task automatic ev_case(int g, int b, logic exp_irq, logic [7:0] exp);
    @(posedge clk_i) drv(g, b, 1'b1, 1'b0);
    @(posedge clk_i) drv(g, b, 1'b0, 1'b0);
    #1 chk1("irq", exp_irq, irq_o);
    @(posedge clk_i) #1 chk1("irq pulse end", 1'b0, irq_o);
    rd_chk(addr_of(g), exp);
    @(posedge clk_i) drv(g, b, 1'b0, 1'b1);
    @(posedge clk_i) drv(g, b, 1'b0, 1'b0);
    rd_chk(addr_of(g), 8'h00);
  endtask : ev_case

  task automatic reset_values;
    rd_chk(16'h2009, 8'h00);
    rd_chk(16'h200B, 8'h00);
    rd_chk(16'h200C, 8'h00);
    rd_chk(16'h2010, 8'h02);
    rd_chk(16'h2011, 8'h00);
    rd_chk(16'h2005, 8'h00);
    wr(16'h200B, 8'hFF);
    rd_chk(16'h200B, 8'h00);
  endtask : reset_values

  task automatic default_unmask;
    ev_case(1, 1, 1'b1, 8'h02);
    ev_case(1, 0, 1'b0, 8'h00);
  endtask : default_unmask

  task automatic every_bit;
    for (int b = 0; b < 4; b++) ev_case(0, b, 1'b0, 8'h01 << b);
    wr(16'h2010, 8'hFF);
    wr(16'h2011, 8'hFF);
    rd_chk(16'h2011, 8'hF7);
    for (int b = 0; b < 8; b++) ev_case(1, b, 1'b1, 8'h01 << b);
    for (int b = 0; b < 8; b++) ev_case(2, b, b != 3, (b == 3) ? 8'h00 : 8'h01 << b);
  endtask : every_bit

  // Masked edge is remembered and shows once unmasked
  task automatic mask_and_disable;
    wr(16'h2010, 8'h00);
    @(posedge clk_i) drv(1, 7, 1'b1, 1'b0);
    @(posedge clk_i) drv(1, 7, 1'b0, 1'b0);
    #1 chk1("irq masked", 1'b0, irq_o);
    rd_chk(16'h200B, 8'h00);
    wr(16'h2010, 8'h80);
    rd_chk(16'h200B, 8'h80);
    // Read right behind an unmask clear must already show zero
    @(posedge clk_i) {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, FAULT_UNMASK_REG, 8'h00};
    @(posedge clk_i) {reg_wr_i, reg_rd_i, reg_addr_i} <= {2'b01, THERMAL_FAULT_FLAGS};
    @(posedge clk_i) reg_rd_i <= 1'b0;
    #1 chk8("flags after unmask clear", 8'h00, reg_rdata_o);
    @(posedge clk_i) drv(1, 7, 1'b0, 1'b1);
    @(posedge clk_i) drv(1, 7, 1'b0, 1'b0);
    wr(16'h2010, 8'hFF);
    @(posedge clk_i) irq_enable_i <= 1'b0;
    ev_case(1, 3, 1'b0, 8'h08);
    @(posedge clk_i) irq_enable_i <= 1'b1;
  endtask : mask_and_disable

  // Rise and clear in the same cycle: the rise must survive
  task automatic set_beats_clear;
    @(posedge clk_i) drv(1, 0, 1'b1, 1'b1);
    @(posedge clk_i) drv(1, 0, 1'b0, 1'b0);
    rd_chk(16'h200B, 8'h01);
    @(posedge clk_i) drv(1, 0, 1'b0, 1'b1);
    @(posedge clk_i) drv(1, 0, 1'b0, 1'b0);
    rd_chk(16'h200B, 8'h00);
  endtask : set_beats_clear

  // Reset in mid-run drops a pending flag and restores the unmasks
  task automatic mid_reset;
    @(posedge clk_i) drv(1, 6, 1'b1, 1'b0);
    @(posedge clk_i) drv(1, 6, 1'b0, 1'b0);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    reset_values();
  endtask : mid_reset

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done

  // Watchdog, well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    test_done();
  end

  // Main sequence
  initial begin
    // Past time zero, so every flop sees the asynchronous reset edge
    #1;
    {resetn_i, brownout_raw_i, brownout_clear_i, fault_raw_i, fault_clear_i} = '0;
    {monitor_raw_i, monitor_clear_i, reg_rd_i, reg_wr_i, reg_addr_i, reg_wdata_i} = '0;
    irq_enable_i = 1'b1;
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    reset_values();
    default_unmask();
    every_bit();
    mask_and_disable();
    set_beats_clear();
    mid_reset();
    test_done();
  end
endmodule : test_amp_event_flags
`default_nettype wire
